// ### odr_output_disable.sv
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ns
// Functional notes
// - Mode 00: falling edge accepts request
// - Mode 01: 16 low samples at clk/8
// - Mode 10: 16 low samples at clk/16
// - Mode 11: 16 low samples at clk/128
// - Request flag set once request accepted
// - Each fault input: own mode, own flag
// - Short enable disables group on overlap
// - Two independent short groups, own enables
// - Level register A: six pin levels
// - Level register B: six pin levels
// - Level register C only on variant
// - Per-input stop enable gates output disable
// - Overlap of one cycle triggers short
module odr_output_disable #(
    parameter bit HAS_LEVEL_C = 1'b0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [odr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [odr_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [odr_pkg::DATA_W-1:0] o_rdata,
    // Fault inputs, active low
    input wire logic i_fault_in_a_n,
    input wire logic i_fault_in_b_n,
    input wire logic i_fault_in_c_n,
    // Monitored output pins, pair k is bits 2k (A) and 2k+1 (B)
    input wire logic [odr_pkg::NUM_GRP-1:0][odr_pkg::PIN_W-1:0] i_pwm_pins,
    // Output stop and interrupt
    output logic [odr_pkg::NUM_GRP-1:0] o_out_disable,
    output logic o_irq
);
    odr_pkg::odr_state_t s_r;
    odr_pkg::odr_state_t s_nxt;
    logic [odr_pkg::NUM_FAULT-1:0] fault_n;
    logic tick_d8;
    logic tick_d16;
    logic tick_d128;
    logic [odr_pkg::NUM_FAULT-1:0] tick_sel;
    logic [odr_pkg::NUM_GRP-1:0] both_act;
    logic fault_stop;

    assign fault_n = {i_fault_in_c_n, i_fault_in_b_n, i_fault_in_a_n};
    assign tick_d8 = (s_r.presc & odr_pkg::MASK_DIV8) == odr_pkg::MASK_DIV8;
    assign tick_d16 = (s_r.presc & odr_pkg::MASK_DIV16) == odr_pkg::MASK_DIV16;
    assign tick_d128 = (s_r.presc & odr_pkg::MASK_DIV128) == odr_pkg::MASK_DIV128;

    always_comb begin
        for (int f = 0; f < odr_pkg::NUM_FAULT; f++) begin
            unique case (s_r.fault[f].mode)
                odr_pkg::MODE_DIV8: tick_sel[f] = tick_d8;
                odr_pkg::MODE_DIV16: tick_sel[f] = tick_d16;
                odr_pkg::MODE_DIV128: tick_sel[f] = tick_d128;
                odr_pkg::MODE_EDGE: tick_sel[f] = 1'b0;
            endcase
        end
    end

    // Pair overlap: both pins of a pair at their programmed active level
    always_comb begin
        for (int g = 0; g < odr_pkg::NUM_GRP; g++) begin
            both_act[g] = 1'b0;
            for (int p = 0; p < odr_pkg::PIN_W; p += 2) begin
                both_act[g] = both_act[g] |
                    ((i_pwm_pins[g][p] == s_r.lvl[g][p]) &&
                     (i_pwm_pins[g][p+1] == s_r.lvl[g][p+1]));
            end
        end
    end

    always_comb begin
        logic [odr_pkg::NUM_FAULT-1:0] accept;
        logic [odr_pkg::NUM_GRP-1:0] short_hit;
        accept = '0;
        short_hit = '0;
        s_nxt = s_r;
        s_nxt.rdata = '0;
        s_nxt.presc = s_r.presc + 7'h01;

        // Fault input detection, one independent channel per input
        for (int f = 0; f < odr_pkg::NUM_FAULT; f++) begin
            s_nxt.prev[f] = fault_n[f];
            if (s_r.fault[f].mode == odr_pkg::MODE_EDGE) begin
                s_nxt.cnt[f] = '0;
                accept[f] = s_r.prev[f] & ~fault_n[f];
            end else if (tick_sel[f]) begin
                if (fault_n[f]) begin
                    s_nxt.cnt[f] = '0;
                end else if (s_r.cnt[f] == odr_pkg::SAMPLE_LAST) begin
                    s_nxt.cnt[f] = odr_pkg::SAMPLE_FULL;
                    accept[f] = 1'b1;
                end else if (s_r.cnt[f] != odr_pkg::SAMPLE_FULL) begin
                    s_nxt.cnt[f] = s_r.cnt[f] + 5'h01;
                end
            end
        end

        for (int g = 0; g < odr_pkg::NUM_GRP; g++) begin
            short_hit[g] = s_r.short_en[g] & both_act[g];
        end

        // Register writes; clears come first so a same-cycle event wins
        if (i_wr) begin
            for (int f = 0; f < odr_pkg::NUM_FAULT; f++) begin
                if (i_addr == odr_pkg::ADDR_ICS_BASE + 4'(f)) begin
                    s_nxt.fault[f].mode = i_wdata[odr_pkg::MODE_LSB +: 2];
                    s_nxt.fault[f].stop_en = i_wdata[odr_pkg::STOP_EN_BIT];
                    if (!i_wdata[odr_pkg::FLAG_BIT]) begin
                        s_nxt.fault[f].flag = 1'b0;
                    end
                    if (i_wdata[odr_pkg::MODE_LSB +: 2] != s_r.fault[f].mode) begin
                        s_nxt.cnt[f] = '0;
                    end
                end
            end
            for (int g = 0; g < odr_pkg::NUM_GRP; g++) begin
                if (i_addr == odr_pkg::ADDR_SHORT_BASE + 4'(g)) begin
                    s_nxt.short_en[g] = i_wdata[odr_pkg::SHORT_EN_BIT];
                    if (!i_wdata[odr_pkg::SHORT_FLAG_BIT]) begin
                        s_nxt.short_flag[g] = 1'b0;
                    end
                end
            end
            for (int l = 0; l < odr_pkg::NUM_LVL; l++) begin
                if (i_addr == odr_pkg::ADDR_LVL_BASE + 4'(l) &&
                    (l < odr_pkg::NUM_GRP || HAS_LEVEL_C)) begin
                    s_nxt.lvl[l] = i_wdata[odr_pkg::PIN_W-1:0];
                end
            end
            if (i_addr == odr_pkg::ADDR_IRQ_CLEAR) begin
                s_nxt.irq_st = s_r.irq_st & ~i_wdata[odr_pkg::NUM_EVT-1:0];
            end
            if (i_addr == odr_pkg::ADDR_IRQ_ENABLE) begin
                s_nxt.irq_en = i_wdata[odr_pkg::NUM_EVT-1:0];
            end
        end

        // Hardware sets after software clears
        for (int f = 0; f < odr_pkg::NUM_FAULT; f++) begin
            if (accept[f]) begin
                s_nxt.fault[f].flag = 1'b1;
                s_nxt.irq_st[f] = 1'b1;
            end
        end
        for (int g = 0; g < odr_pkg::NUM_GRP; g++) begin
            if (short_hit[g]) begin
                s_nxt.short_flag[g] = 1'b1;
                s_nxt.irq_st[odr_pkg::EVT_SHORT_LSB + g] = 1'b1;
            end
        end

        // Read data, valid the cycle after the strobe
        if (i_rd) begin
            for (int f = 0; f < odr_pkg::NUM_FAULT; f++) begin
                if (i_addr == odr_pkg::ADDR_ICS_BASE + 4'(f)) begin
                    s_nxt.rdata[odr_pkg::MODE_LSB +: 2] = s_r.fault[f].mode;
                    s_nxt.rdata[odr_pkg::STOP_EN_BIT] = s_r.fault[f].stop_en;
                    s_nxt.rdata[odr_pkg::FLAG_BIT] = s_r.fault[f].flag;
                end
            end
            for (int g = 0; g < odr_pkg::NUM_GRP; g++) begin
                if (i_addr == odr_pkg::ADDR_SHORT_BASE + 4'(g)) begin
                    s_nxt.rdata[odr_pkg::SHORT_EN_BIT] = s_r.short_en[g];
                    s_nxt.rdata[odr_pkg::SHORT_FLAG_BIT] = s_r.short_flag[g];
                end
            end
            for (int l = 0; l < odr_pkg::NUM_LVL; l++) begin
                if (i_addr == odr_pkg::ADDR_LVL_BASE + 4'(l) &&
                    (l < odr_pkg::NUM_GRP || HAS_LEVEL_C)) begin
                    s_nxt.rdata[odr_pkg::PIN_W-1:0] = s_r.lvl[l];
                end
            end
            if (i_addr == odr_pkg::ADDR_IRQ_STATUS) begin
                s_nxt.rdata[odr_pkg::NUM_EVT-1:0] = s_r.irq_st;
            end
            if (i_addr == odr_pkg::ADDR_IRQ_ENABLE) begin
                s_nxt.rdata[odr_pkg::NUM_EVT-1:0] = s_r.irq_en;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // An accepted fault with its stop enable set stops both groups; a short stops only its own group
    always_comb begin
        fault_stop = 1'b0;
        for (int f = 0; f < odr_pkg::NUM_FAULT; f++) begin
            fault_stop = fault_stop | (s_r.fault[f].flag & s_r.fault[f].stop_en);
        end
        for (int g = 0; g < odr_pkg::NUM_GRP; g++) begin
            o_out_disable[g] = fault_stop | s_r.short_flag[g];
        end
    end

    assign o_rdata = s_r.rdata;
    assign o_irq = |(s_r.irq_st & s_r.irq_en);

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence seq_fall_a;
        s_r.fault[0].mode == odr_pkg::MODE_EDGE && s_r.prev[0] && !i_fault_in_a_n;
    endsequence

    sequence seq_flag_b_kept;
        s_r.fault[1].flag && !(i_wr && i_addr == odr_pkg::ADDR_ICS_BASE + 4'h1);
    endsequence

    chk_edge_accept_a: assert property (seq_fall_a |=> s_r.fault[0].flag)
        else $error("falling edge not accepted on input a");

    chk_div8_filter_a: assert property ($rose(s_r.fault[0].flag) &&
        $past(s_r.fault[0].mode) == odr_pkg::MODE_DIV8 |->
        $past(tick_d8) && $past(s_r.cnt[0]) == odr_pkg::SAMPLE_LAST)
        else $error("div8 request accepted without sixteen low samples");

    chk_div16_filter_b: assert property ($rose(s_r.fault[1].flag) &&
        $past(s_r.fault[1].mode) == odr_pkg::MODE_DIV16 |->
        $past(tick_d16) && $past(s_r.cnt[1]) == odr_pkg::SAMPLE_LAST)
        else $error("div16 request accepted without sixteen low samples");

    chk_div128_filter_c: assert property ($rose(s_r.fault[2].flag) &&
        $past(s_r.fault[2].mode) == odr_pkg::MODE_DIV128 |->
        $past(tick_d128) && $past(s_r.cnt[2]) == odr_pkg::SAMPLE_LAST)
        else $error("div128 request accepted without sixteen low samples");

    chk_flag_sticky_b: assert property (seq_flag_b_kept |=> s_r.fault[1].flag)
        else $error("request flag dropped without a clear");

    chk_high_resets_cnt: assert property (s_r.fault[2].mode != odr_pkg::MODE_EDGE && tick_sel[2] &&
        i_fault_in_c_n && !i_wr |=> s_r.cnt[2] == '0)
        else $error("high sample did not restart the low count");

    chk_short_detect: assert property (s_r.short_en[0] && both_act[0] |=> s_r.short_flag[0] ##0
        o_out_disable[0])
        else $error("pair overlap did not disable group a");

    chk_short_needs_en: assert property ($rose(s_r.short_flag[1]) |-> $past(s_r.short_en[1]))
        else $error("group b short set while its detection was off");

    chk_stop_hold_c: assert property (s_r.fault[2].flag && s_r.fault[2].stop_en |->
        o_out_disable == '1)
        else $error("outputs released while stop request stands");

    chk_level_c_absent: assert property (!HAS_LEVEL_C && i_rd &&
        i_addr == odr_pkg::ADDR_LVL_BASE + 4'h2 |=> o_rdata == '0)
        else $error("absent level register c read non-zero");

    // Helpers for the assertions below
    logic [odr_pkg::PIN_W-1:0] wr_lvl;
    logic [odr_pkg::NUM_FAULT-1:0] stop_req;
    assign wr_lvl = i_wdata[odr_pkg::PIN_W-1:0];
    assign stop_req = {s_r.fault[2].flag & s_r.fault[2].stop_en, s_r.fault[1].flag & s_r.fault[1].stop_en,
        s_r.fault[0].flag & s_r.fault[0].stop_en};

    sequence seq_fall_b;
        s_r.fault[1].mode == odr_pkg::MODE_EDGE && s_r.prev[1] && !i_fault_in_b_n;
    endsequence

    sequence seq_fall_c;
        s_r.fault[2].mode == odr_pkg::MODE_EDGE && s_r.prev[2] && !i_fault_in_c_n;
    endsequence

    sequence seq_flag_a_kept;
        s_r.fault[0].flag && !(i_wr && i_addr == odr_pkg::ADDR_ICS_BASE);
    endsequence

    sequence seq_flag_c_kept;
        s_r.fault[2].flag && !(i_wr && i_addr == odr_pkg::ADDR_ICS_BASE + 4'h2);
    endsequence

    sequence seq_overlap_b;
        s_r.short_en[1] && both_act[1];
    endsequence

    sequence seq_level_a_wr;
        i_wr && i_addr == odr_pkg::ADDR_LVL_BASE;
    endsequence

    sequence seq_level_b_wr;
        i_wr && i_addr == odr_pkg::ADDR_LVL_BASE + 4'h1;
    endsequence

    sequence seq_flag_a_read;
        i_rd && i_addr == odr_pkg::ADDR_ICS_BASE;
    endsequence

    sequence seq_short_a_kept;
        s_r.short_flag[0] && !(i_wr && i_addr == odr_pkg::ADDR_SHORT_BASE);
    endsequence

    chk_edge_accept_b: assert property (seq_fall_b |=> s_r.fault[1].flag)
        else $error("falling edge not accepted on input b");

    chk_edge_accept_c: assert property (seq_fall_c |=> s_r.fault[2].flag)
        else $error("falling edge not accepted on input c");

    chk_edge_needs_fall: assert property ($rose(s_r.fault[0].flag) &&
        $past(s_r.fault[0].mode) == odr_pkg::MODE_EDGE |-> $past(s_r.prev[0]) && !$past(i_fault_in_a_n))
        else $error("edge-mode request accepted without a falling edge");

    chk_flag_sticky_a: assert property (seq_flag_a_kept |=> s_r.fault[0].flag)
        else $error("input a flag dropped without a clear");

    chk_flag_sticky_c: assert property (seq_flag_c_kept |=> s_r.fault[2].flag)
        else $error("input c flag dropped without a clear");

    chk_short_detect_b: assert property (seq_overlap_b |=> s_r.short_flag[1] ##0 o_out_disable[1])
        else $error("pair overlap did not disable group b");

    chk_short_needs_en_a: assert property ($rose(s_r.short_flag[0]) |-> $past(s_r.short_en[0]))
        else $error("group a short set while its detection was off");

    chk_short_sticky_a: assert property (seq_short_a_kept |=> s_r.short_flag[0])
        else $error("group a short flag dropped without a clear");

    chk_short_own_group: assert property (stop_req == '0 |-> o_out_disable == s_r.short_flag)
        else $error("short of one group stopped the other group");

    chk_stop_hold_a: assert property (stop_req[0] |-> o_out_disable == '1)
        else $error("outputs released while input a stop request stands");

    chk_stop_hold_b: assert property (stop_req[1] |-> o_out_disable == '1)
        else $error("outputs released while input b stop request stands");

    chk_no_stop_req: assert property (!s_r.fault[0].stop_en && !s_r.fault[1].stop_en &&
        !s_r.fault[2].stop_en && s_r.short_flag == '0 |-> o_out_disable == '0)
        else $error("outputs stopped with every stop enable off");

    chk_irq_on_fault_a: assert property ($rose(s_r.fault[0].flag) |-> s_r.irq_st[0])
        else $error("input a request did not raise its status bit");

    chk_irq_on_short_b: assert property ($rose(s_r.short_flag[1]) |-> s_r.irq_st[odr_pkg::EVT_SHORT_LSB + 1])
        else $error("group b short did not raise its status bit");

    chk_flag_read_a: assert property (seq_flag_a_read |=> o_rdata[odr_pkg::FLAG_BIT] == $past(s_r.fault[0].flag))
        else $error("input a flag read back wrong");

    chk_count_cap_a: assert property (s_r.cnt[0] <= odr_pkg::SAMPLE_FULL)
        else $error("input a low count ran past sixteen");

    chk_count_cap_b: assert property (s_r.cnt[1] <= odr_pkg::SAMPLE_FULL)
        else $error("input b low count ran past sixteen");

    chk_count_cap_c: assert property (s_r.cnt[2] <= odr_pkg::SAMPLE_FULL)
        else $error("input c low count ran past sixteen");

    chk_edge_no_count_b: assert property (s_r.fault[1].mode == odr_pkg::MODE_EDGE |=> s_r.cnt[1] == '0)
        else $error("edge mode left a low count on input b");

    chk_mode_change_cnt: assert property (i_wr && i_addr == odr_pkg::ADDR_ICS_BASE + 4'h1 &&
        i_wdata[odr_pkg::MODE_LSB +: 2] != s_r.fault[1].mode |=> s_r.cnt[1] == '0)
        else $error("mode change did not restart the low count");

    chk_level_a_write: assert property (seq_level_a_wr |=> s_r.lvl[0] == $past(wr_lvl))
        else $error("level register a did not take the write");

    chk_level_b_write: assert property (seq_level_b_wr |=> s_r.lvl[1] == $past(wr_lvl))
        else $error("level register b did not take the write");
endmodule

// ### odr_pkg.sv
package odr_pkg;
    localparam int NUM_FAULT = 3;
    localparam int NUM_GRP = 2;
    localparam int NUM_LVL = 3;
    localparam int PIN_W = 6;
    localparam int NUM_EVT = 5;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int PRESC_W = 7;
    localparam int CNT_W = 5;

    // Register addresses
    localparam logic [3:0] ADDR_ICS_BASE = 4'h0;
    localparam logic [3:0] ADDR_SHORT_BASE = 4'h3;
    localparam logic [3:0] ADDR_LVL_BASE = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h9;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'ha;

    // Field positions
    localparam int MODE_LSB = 0;
    localparam int STOP_EN_BIT = 8;
    localparam int FLAG_BIT = 15;
    localparam int SHORT_EN_BIT = 0;
    localparam int SHORT_FLAG_BIT = 15;
    localparam int EVT_SHORT_LSB = 3;

    // Detection modes
    localparam logic [1:0] MODE_EDGE = 2'h0;
    localparam logic [1:0] MODE_DIV8 = 2'h1;
    localparam logic [1:0] MODE_DIV16 = 2'h2;
    localparam logic [1:0] MODE_DIV128 = 2'h3;

    // Prescaler masks for the sampling clocks
    localparam logic [PRESC_W-1:0] MASK_DIV8 = 7'h07;
    localparam logic [PRESC_W-1:0] MASK_DIV16 = 7'h0f;
    localparam logic [PRESC_W-1:0] MASK_DIV128 = 7'h7f;

    // Low-sample counter marks
    localparam logic [CNT_W-1:0] SAMPLE_LAST = 5'h0f;
    localparam logic [CNT_W-1:0] SAMPLE_FULL = 5'h10;

    typedef struct packed {
        logic [1:0] mode;
        logic stop_en;
        logic flag;
    } odr_fault_t;

    typedef struct packed {
        odr_fault_t [NUM_FAULT-1:0] fault;
        logic [NUM_FAULT-1:0] prev;
        logic [NUM_FAULT-1:0][CNT_W-1:0] cnt;
        logic [NUM_GRP-1:0] short_en;
        logic [NUM_GRP-1:0] short_flag;
        logic [NUM_LVL-1:0][PIN_W-1:0] lvl;
        logic [NUM_EVT-1:0] irq_st;
        logic [NUM_EVT-1:0] irq_en;
        logic [PRESC_W-1:0] presc;
        logic [DATA_W-1:0] rdata;
    } odr_state_t;
endpackage

// ### odr_far_side.sv
`timescale 1ns/1ns
module odr_far_side (
    // Clock
    input wire logic i_clk,
    // Fault lines, pulled up on the board
    output logic o_fault_in_a_n,
    output logic o_fault_in_b_n,
    output logic o_fault_in_c_n,
    // Timer output pins
    output logic [odr_pkg::NUM_GRP-1:0][odr_pkg::PIN_W-1:0] o_pwm_pins
);
    logic [2:0] fault_n_r = 3'h7;
    assign o_fault_in_a_n = fault_n_r[0];
    assign o_fault_in_b_n = fault_n_r[1];
    assign o_fault_in_c_n = fault_n_r[2];
    initial begin
        o_pwm_pins = '0;
    end
    // Lines change just after an edge
    task automatic set_fault(input int idx, input logic lvl);
        @(posedge i_clk);
        fault_n_r[idx] <= lvl;
    endtask
    task automatic set_pins(input int g, input logic [5:0] val);
        @(posedge i_clk);
        o_pwm_pins[g] <= val;
    endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [odr_pkg::ADDR_W-1:0] i_addr = 4'h0;
    logic [odr_pkg::DATA_W-1:0] i_wdata = 16'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [odr_pkg::DATA_W-1:0] o_rdata;
    logic fa_n, fb_n, fc_n;
    logic [odr_pkg::NUM_GRP-1:0][odr_pkg::PIN_W-1:0] pins;
    logic [odr_pkg::NUM_GRP-1:0] o_out_disable;
    logic o_irq;
    int n_errors = 0;
    int comparisons = 0;
    int n;
    always #50 i_clk = ~i_clk;
    odr_output_disable odr_output_disable_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fault_in_a_n(fa_n),
        .i_fault_in_b_n(fb_n), .i_fault_in_c_n(fc_n), .i_pwm_pins(pins),
        .o_out_disable(o_out_disable), .o_irq(o_irq));
    odr_far_side odr_far_side_inst (.i_clk(i_clk), .o_fault_in_a_n(fa_n), .o_fault_in_b_n(fb_n),
        .o_fault_in_c_n(fc_n), .o_pwm_pins(pins));
    task automatic conclude();
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
    endtask
    task automatic dis_chk(input logic [1:0] exp);
        @(posedge i_clk);
        #1;
        check({14'h0, o_out_disable}, {14'h0, exp});
    endtask
    // Bounded wait for the stop outputs, cycles counted in n
    task automatic wait_dis(input logic [1:0] exp, input int bound);
        n = 0;
        while (o_out_disable !== exp && n < bound) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (o_out_disable !== exp) begin
            check({14'h0, o_out_disable}, {14'h0, exp});
            conclude();
        end
    endtask
    task automatic t_reset();
        for (int a = 0; a < 12; a++) begin
            rd_chk(a[3:0], 16'h0000);
        end
    endtask
    task automatic t_edge();
        wr(4'h0, 16'h0100);
        odr_far_side_inst.set_fault(0, 1'b0);
        wait_dis(2'h3, 4);
        odr_far_side_inst.set_fault(0, 1'b1);
        rd_chk(4'h0, 16'h8100);
        rd_chk(4'h8, 16'h0001);
        repeat (5) dis_chk(2'h3);
        wr(4'h0, 16'h0100);
        dis_chk(2'h0);
        odr_far_side_inst.set_fault(1, 1'b0);
        repeat (4) dis_chk(2'h0);
        rd_chk(4'h1, 16'h8000);
        rd_chk(4'h0, 16'h0100);
        odr_far_side_inst.set_fault(1, 1'b1);
        wr(4'h1, 16'h0000);
        wr(4'h9, 16'h001f);
    endtask
    // Low-level filter: flag after 16 low ticks of the divided clock
    task automatic t_sample(input logic [1:0] mode, input int f, input int div);
        wr(f[3:0], {14'h0040, mode});
        odr_far_side_inst.set_fault(f, 1'b0);
        wait_dis(2'h3, 16 * div + 4);
        check({15'h0, n >= 15 * div + 1 && n <= 16 * div + 2}, 16'h0001);
        rd_chk(f[3:0], {14'h2040, mode});
        odr_far_side_inst.set_fault(f, 1'b1);
        wr(f[3:0], {14'h0040, mode});
        wr(4'h9, 16'h001f);
        dis_chk(2'h0);
    endtask
    task automatic t_short();
        wr(4'h5, 16'h003f);
        rd_chk(4'h5, 16'h003f);
        rd_chk(4'h6, 16'h0000);
        wr(4'h7, 16'h003f);
        rd_chk(4'h7, 16'h0000);
        odr_far_side_inst.set_pins(0, 6'h03);
        repeat (3) dis_chk(2'h0);
        wr(4'h3, 16'h0001);
        wait_dis(2'h1, 3);
        odr_far_side_inst.set_pins(0, 6'h01);
        rd_chk(4'h3, 16'h8001);
        wr(4'h4, 16'h0001);
        odr_far_side_inst.set_pins(1, 6'h3c);
        odr_far_side_inst.set_pins(1, 6'h3f);
        wait_dis(2'h3, 3);
        wr(4'ha, 16'h0018);
        dis_chk(2'h3);
        check({15'h0, o_irq}, 16'h0001);
        rd_chk(4'h8, 16'h0018);
        wr(4'ha, 16'h0000);
        dis_chk(2'h3);
        check({15'h0, o_irq}, 16'h0000);
        wr(4'h9, 16'h0018);
        rd_chk(4'h8, 16'h0000);
        wr(4'h3, 16'h0000);
        wr(4'h4, 16'h0000);
        dis_chk(2'h0);
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_edge();
        t_sample(2'h1, 0, 8);
        t_sample(2'h2, 1, 16);
        t_sample(2'h3, 2, 128);
        t_short();
        conclude();
    end
endmodule
